//--- rtl/eimh_ext_io.sv
`timescale 1ns/100ps
`default_nettype none
module eimh_ext_io
    import eimh_pkg::*;
#(
    parameter int CYC_US = CYC_PER_US,
    parameter int CAL_SECOND_US_P = CAL_SECOND_US,
    parameter int CAL_RUN_US_P = CAL_RUN_US
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DW-1:0] regRdata,
    // Control inputs from the external controller
    input wire logic startIn,
    input wire logic stopIn,
    input wire logic measureTriggerIn,
    // Results from the analogue measurement core
    input wire logic contactOkIn,
    input wire logic voltOkIn,
    input wire logic cmpHiIn,
    input wire logic cmpInIn,
    input wire logic cmpLoIn,
    input wire logic measErrIn,
    // Analogue control
    output logic voltageDriveOut,
    output logic dischargeOut,
    output logic calRunOut,
    // Output terminals, electrical level
    output logic acqDoneOut,
    output logic measurementDoneOut,
    output logic contactPassOut,
    output logic voltCheckPassOut,
    output logic judgeHiOut,
    output logic judgeInOut,
    output logic judgeLoOut,
    output logic judgePassOut,
    output logic judgeFailOut,
    output logic measErrOut,
    output logic voltOnOut
);
    eimh_state_t state_r, state_nxt;
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [RW-1:0] ccDly_r, ccDly_nxt, dly_r, dly_nxt;
    logic [RW-1:0] meas_r, meas_nxt, comp_r, comp_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic startD_r, stopD_r, trigD_r;
    logic acq_r, acq_nxt, md_r, md_nxt, cc_r, cc_nxt, vck_r, vck_nxt;
    logic hi_r, hi_nxt, in_r, in_nxt, lo_r, lo_nxt;
    logic pass_r, pass_nxt, fail_r, fail_nxt, err_r, err_nxt;
    logic seqPend_r, seqPend_nxt, calDue_r, calDue_nxt;
    logic calArmed_r, calArmed_nxt;
    logic vDrive_r, vDrive_nxt, vOn_r, vOn_nxt, vFall_r, vFall_nxt;
    logic [NOUT-1:0] outLog, pinLvl_r;
    logic startEdge, stopEdge, trigEdge, trigGo, seqEnd;
    logic seqLoad, seqBusy, vLoad, vBusy, calLoad, calBusy;
    logic [TW-1:0] seqLoadUs, vLoadUs, ccDlyEff;
    logic [1:0] mode;
    logic disch, ccEn;

    assign mode = ctrl_r[CTRL_MODE +: 2];
    assign disch = ctrl_r[CTRL_DISCH];
    assign ccEn = ctrl_r[CTRL_CCEN];
    assign startEdge = startIn & ~startD_r;
    assign stopEdge = stopIn & ~stopD_r;
    assign trigEdge = measureTriggerIn & ~trigD_r;
    // Longer delays would push the contact result past its window
    assign ccDlyEff = (ccDly_r > RW'(CC_DELAY_MAX_US)) ?
        TW'(CC_DELAY_MAX_US) : TW'(ccDly_r);

    eimh_timer #(.W(TW), .CYC_US(CYC_US)) seqTimer (
        .ref_clk(ref_clk), .nrst(nrst), .load(seqLoad),
        .loadUs(seqLoadUs), .busy(seqBusy)
    );
    eimh_timer #(.W(TW), .CYC_US(CYC_US)) voltTimer (
        .ref_clk(ref_clk), .nrst(nrst), .load(vLoad),
        .loadUs(vLoadUs), .busy(vBusy)
    );
    eimh_timer #(.W(TW), .CYC_US(CYC_US)) calTimer (
        .ref_clk(ref_clk), .nrst(nrst), .load(calLoad),
        .loadUs(TW'(CAL_SECOND_US_P)), .busy(calBusy)
    );

    // Trigger source per mode; only taken while idle
    always_comb begin
        case (mode)
            MODE_EXT: trigGo = trigEdge;
            MODE_SEQ: trigGo = seqPend_r & vOn_r;
            MODE_INT: trigGo = 1'b1;
            default: trigGo = 1'b0;
        endcase
    end

    // Measurement sequencer
    always_comb begin
        state_nxt = state_r;
        seqLoad = 1'b0;
        seqLoadUs = '0;
        seqEnd = 1'b0;
        calLoad = 1'b0;
        acq_nxt = acq_r;
        md_nxt = md_r;
        cc_nxt = cc_r;
        vck_nxt = vck_r;
        hi_nxt = hi_r;
        in_nxt = in_r;
        lo_nxt = lo_r;
        pass_nxt = pass_r;
        fail_nxt = fail_r;
        err_nxt = err_r;
        calDue_nxt = calDue_r;
        calArmed_nxt = calArmed_r;
        seqPend_nxt = seqPend_r;
        if (mode == MODE_SEQ && startEdge) begin
            seqPend_nxt = 1'b1;
        end
        if (stopEdge || mode != MODE_SEQ) begin
            seqPend_nxt = 1'b0;
        end
        if (calArmed_r && !calBusy) begin
            calDue_nxt = 1'b1;
            calArmed_nxt = 1'b0;
        end
        case (state_r)
            ST_BOOT: begin
                seqLoad = 1'b1;
                seqLoadUs = TW'(CAL_RUN_US_P);
                calLoad = 1'b1;
                calArmed_nxt = 1'b1;
                state_nxt = ST_CAL;
            end
            ST_CAL: begin
                if (!seqBusy) begin
                    acq_nxt = 1'b1;
                    md_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (calDue_r) begin
                    calDue_nxt = 1'b0;
                    seqLoad = 1'b1;
                    seqLoadUs = TW'(CAL_RUN_US_P);
                    state_nxt = ST_CAL;
                end else if (trigGo) begin
                    acq_nxt = 1'b0;
                    md_nxt = 1'b0;
                    seqPend_nxt = 1'b0;
                    seqLoad = 1'b1;
                    // Internal trigger has no contact-check delay
                    seqLoadUs = (ccEn && mode != MODE_INT) ?
                        ccDlyEff : '0;
                    state_nxt = ST_CCDLY;
                end
            end
            ST_CCDLY: begin
                if (!seqBusy) begin
                    seqLoad = 1'b1;
                    seqLoadUs = ccEn ? TW'(CC_TIME_US) : '0;
                    state_nxt = ST_CCRUN;
                end
            end
            ST_CCRUN: begin
                if (!seqBusy) begin
                    cc_nxt = ccEn & contactOkIn;
                    seqLoad = 1'b1;
                    seqLoadUs = TW'(dly_r);
                    state_nxt = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!seqBusy) begin
                    seqLoad = 1'b1;
                    seqLoadUs = TW'(meas_r);
                    state_nxt = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (!seqBusy) begin
                    acq_nxt = 1'b1;
                    seqLoad = 1'b1;
                    // Judgment setup is carved out of the allowed total
                    seqLoadUs = TW'(comp_r) +
                        TW'(COMP_EXTRA_US - JUDGE_SETUP_US) +
                        (ctrl_r[CTRL_VCALC] ? TW'(VCALC_EXTRA_US) : '0);
                    state_nxt = ST_COMP;
                end
            end
            ST_COMP: begin
                if (!seqBusy) begin
                    hi_nxt = cmpHiIn;
                    in_nxt = cmpInIn;
                    lo_nxt = cmpLoIn;
                    err_nxt = measErrIn;
                    vck_nxt = voltOkIn;
                    pass_nxt = ~measErrIn & cmpInIn;
                    fail_nxt = ~measErrIn & ~cmpInIn;
                    seqLoad = 1'b1;
                    seqLoadUs = TW'(JUDGE_SETUP_US);
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (!seqBusy) begin
                    md_nxt = 1'b1;
                    seqEnd = (mode == MODE_SEQ);
                    if (mode == MODE_INT) begin
                        seqLoad = 1'b1;
                        seqLoadUs = TW'(INT_MEASURE_TRIGGER_IN_US);
                        state_nxt = ST_INTWAIT;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_INTWAIT: begin
                if (!seqBusy || mode != MODE_INT) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Test voltage control; stop wins over a simultaneous start
    always_comb begin
        vDrive_nxt = vDrive_r;
        vOn_nxt = vOn_r;
        vFall_nxt = vFall_r;
        vLoad = 1'b0;
        vLoadUs = '0;
        if (stopEdge || seqEnd) begin
            vDrive_nxt = 1'b0;
            vOn_nxt = 1'b0;
            vFall_nxt = disch;
            vLoad = 1'b1;
            vLoadUs = disch ? TW'(FALL_DIS_US) : '0;
        end else if (startEdge && !vDrive_r) begin
            vDrive_nxt = 1'b1;
            vOn_nxt = 1'b0;
            vFall_nxt = 1'b0;
            vLoad = 1'b1;
            vLoadUs = disch ? TW'(RISE_DIS_US) : TW'(RISE_HIZ_US);
        end else if (!vBusy) begin
            vOn_nxt = vDrive_r;
            vFall_nxt = 1'b0;
        end
    end

    // Register port
    always_comb begin
        ctrl_nxt = ctrl_r;
        ccDly_nxt = ccDly_r;
        dly_nxt = dly_r;
        meas_nxt = meas_r;
        comp_nxt = comp_r;
        rdata_nxt = '0;
        if (regWr) begin
            case (regAddr)
                REG_CTRL: ctrl_nxt = regWdata[CTRL_W-1:0];
                REG_CC_DELAY: ccDly_nxt = regWdata[RW-1:0];
                REG_DELAY: dly_nxt = regWdata[RW-1:0];
                REG_MEAS: meas_nxt = regWdata[RW-1:0];
                REG_COMP: comp_nxt = regWdata[RW-1:0];
                default: ;
            endcase
        end
        if (regRd) begin
            case (regAddr)
                REG_CTRL: rdata_nxt = DW'(ctrl_r);
                REG_CC_DELAY: rdata_nxt = DW'(ccDly_r);
                REG_DELAY: rdata_nxt = DW'(dly_r);
                REG_MEAS: rdata_nxt = DW'(meas_r);
                REG_COMP: rdata_nxt = DW'(comp_r);
                REG_STATUS: rdata_nxt = DW'({vFall_r, vDrive_r,
                    calRunOut, outLog}) |
                    (DW'(ST_W'(state_r)) << ST_SHIFT);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_comb begin
        outLog = '0;
        outLog[O_ACQ] = acq_r;
        outLog[O_MDONE] = md_r;
        outLog[O_CC] = cc_r;
        outLog[O_VCHK] = vck_r;
        outLog[O_HI] = hi_r;
        outLog[O_IN] = in_r;
        outLog[O_LO] = lo_r;
        outLog[O_PASS] = pass_r;
        outLog[O_FAIL] = fail_r;
        outLog[O_ERR] = err_r;
        outLog[O_VON] = vOn_r;
    end

    // Pin levels follow the selected polarity, one flop per terminal
    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi++) begin : gPin
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    pinLvl_r[gi] <= 1'b0;
                end else begin
                    pinLvl_r[gi] <= outLog[gi] ^ ctrl_r[CTRL_SINK];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_BOOT;
            ctrl_r <= CTRL_RST;
            ccDly_r <= '0;
            dly_r <= '0;
            meas_r <= '0;
            comp_r <= '0;
            rdata_r <= '0;
            startD_r <= 1'b0;
            stopD_r <= 1'b0;
            trigD_r <= 1'b0;
            acq_r <= 1'b0;
            md_r <= 1'b0;
            cc_r <= 1'b0;
            vck_r <= 1'b0;
            hi_r <= 1'b0;
            in_r <= 1'b0;
            lo_r <= 1'b0;
            pass_r <= 1'b0;
            fail_r <= 1'b0;
            err_r <= 1'b0;
            seqPend_r <= 1'b0;
            calDue_r <= 1'b0;
            calArmed_r <= 1'b0;
            vDrive_r <= 1'b0;
            vOn_r <= 1'b0;
            vFall_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            ccDly_r <= ccDly_nxt;
            dly_r <= dly_nxt;
            meas_r <= meas_nxt;
            comp_r <= comp_nxt;
            rdata_r <= rdata_nxt;
            startD_r <= startIn;
            stopD_r <= stopIn;
            trigD_r <= measureTriggerIn;
            acq_r <= acq_nxt;
            md_r <= md_nxt;
            cc_r <= cc_nxt;
            vck_r <= vck_nxt;
            hi_r <= hi_nxt;
            in_r <= in_nxt;
            lo_r <= lo_nxt;
            pass_r <= pass_nxt;
            fail_r <= fail_nxt;
            err_r <= err_nxt;
            seqPend_r <= seqPend_nxt;
            calDue_r <= calDue_nxt;
            calArmed_r <= calArmed_nxt;
            vDrive_r <= vDrive_nxt;
            vOn_r <= vOn_nxt;
            vFall_r <= vFall_nxt;
        end
    end

    assign regRdata = rdata_r;
    assign voltageDriveOut = vDrive_r;
    assign dischargeOut = vFall_r;
    assign calRunOut = (state_r == ST_CAL);
    assign acqDoneOut = pinLvl_r[O_ACQ];
    assign measurementDoneOut = pinLvl_r[O_MDONE];
    assign contactPassOut = pinLvl_r[O_CC];
    assign voltCheckPassOut = pinLvl_r[O_VCHK];
    assign judgeHiOut = pinLvl_r[O_HI];
    assign judgeInOut = pinLvl_r[O_IN];
    assign judgeLoOut = pinLvl_r[O_LO];
    assign judgePassOut = pinLvl_r[O_PASS];
    assign judgeFailOut = pinLvl_r[O_FAIL];
    assign measErrOut = pinLvl_r[O_ERR];
    assign voltOnOut = pinLvl_r[O_VON];
endmodule
`default_nettype wire

//--- rtl/eimh_pkg.sv
package eimh_pkg;

    localparam int CLK_NS = 20;
    localparam int NS_PER_US = 1000;
    localparam int CYC_PER_US = NS_PER_US / CLK_NS;

    localparam int TW = 32;
    localparam int RW = 16;
    localparam int AW = 8;
    localparam int DW = 32;

    // Times in microseconds, CAL_SECOND_S in seconds
    localparam int RISE_DIS_US = 10000;
    localparam int RISE_HIZ_US = 1000;
    localparam int FALL_DIS_US = 10000;
    localparam int CC_WINDOW_US = 3000;
    localparam int CC_TIME_US = 2300;
    localparam int CC_DELAY_MAX_US = CC_WINDOW_US - CC_TIME_US;
    localparam int COMP_EXTRA_US = 400;
    localparam int VCALC_EXTRA_US = 1000;
    localparam int JUDGE_SETUP_US = 70;
    localparam int INT_MEASURE_TRIGGER_IN_US = 40000;
    localparam int CAL_SECOND_S = 300;
    localparam int US_PER_S = 1000000;
    localparam int CAL_SECOND_US = CAL_SECOND_S * US_PER_S;
    localparam int CAL_RUN_US = 1000;

    // Register map
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_CC_DELAY = 8'h04;
    localparam logic [AW-1:0] REG_DELAY = 8'h08;
    localparam logic [AW-1:0] REG_MEAS = 8'h0C;
    localparam logic [AW-1:0] REG_COMP = 8'h10;
    localparam logic [AW-1:0] REG_STATUS = 8'h14;

    // Control fields
    localparam int CTRL_W = 7;
    localparam int CTRL_SINK = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_DISCH = 3;
    localparam int CTRL_VCALC = 4;
    localparam int CTRL_CCEN = 5;
    localparam int CTRL_DISP = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h6A;

    localparam logic [1:0] MODE_INT = 2'h0;
    localparam logic [1:0] MODE_EXT = 2'h1;
    localparam logic [1:0] MODE_SEQ = 2'h2;

    // Logical output vector positions
    localparam int NOUT = 11;
    localparam int O_ACQ = 0;
    localparam int O_MDONE = 1;
    localparam int O_CC = 2;
    localparam int O_VCHK = 3;
    localparam int O_HI = 4;
    localparam int O_IN = 5;
    localparam int O_LO = 6;
    localparam int O_PASS = 7;
    localparam int O_FAIL = 8;
    localparam int O_ERR = 9;
    localparam int O_VON = 10;

    localparam int ST_SHIFT = 16;
    localparam int ST_W = 4;

    typedef enum {
        ST_BOOT, ST_CAL, ST_IDLE, ST_CCDLY, ST_CCRUN, ST_DELAY,
        ST_MEAS, ST_COMP, ST_SETUP, ST_INTWAIT
    } eimh_state_t;

endpackage

//--- rtl/eimh_timer.sv
`timescale 1ns/100ps
`default_nettype none
module eimh_timer #(
    parameter int W = 32,
    parameter int CYC_US = 50
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Load and status
    input wire logic load,
    input wire logic [W-1:0] loadUs,
    output logic busy
);
    localparam int PW = $clog2(CYC_US + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYC_US - 1);

    logic [PW-1:0] pre_r, pre_nxt;
    logic [W-1:0] cnt_r, cnt_nxt;

    // Prescaler restarts on load so a stage lasts exactly N microseconds
    always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        if (load) begin
            pre_nxt = '0;
            cnt_nxt = loadUs;
        end else if (cnt_r != '0) begin
            if (pre_r == PRE_LAST) begin
                pre_nxt = '0;
                cnt_nxt = cnt_r - 1'b1;
            end else begin
                pre_nxt = pre_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pre_r <= '0;
            cnt_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Busy drops in the cycle of the last tick, else each stage runs long
    assign busy = (cnt_r != '0) && !(cnt_r == W'(1) && pre_r == PRE_LAST);
endmodule
`default_nettype wire

//--- test/eimh_ext_io_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module eimh_ext_io_chk
    import eimh_pkg::*;
#(
    parameter int CYC_US = CYC_PER_US
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register writes
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWdata,
    input wire logic regWr,
    // Controller lines
    input wire logic startIn,
    input wire logic stopIn,
    input wire logic measureTriggerIn,
    // Device outputs
    input wire logic voltageDriveOut,
    input wire logic calRunOut,
    input wire logic acqDoneOut,
    input wire logic measurementDoneOut,
    input wire logic judgePassOut,
    input wire logic judgeFailOut,
    input wire logic voltOnOut
);
    localparam int JSET = JUDGE_SETUP_US * CYC_US;
    logic [CTRL_W-1:0] ctrl_r;
    logic sink_r, acqP_r, seen_r;
    logic [RW-1:0] ccd_r, dly_r, meas_r;
    logic [1:0] jdg_r;
    logic [TW-1:0] offCnt_r, ageCnt_r, riseCnt_r, acqLim, riseLim;
    logic acqL, mdL, vonL;

    // Pins follow the polarity one cycle after the control write lands
    assign acqL = acqDoneOut ^ sink_r;
    assign mdL = measurementDoneOut ^ sink_r;
    assign vonL = voltOnOut ^ sink_r;
    assign acqLim = (TW'(ccd_r) + TW'(dly_r) + TW'(meas_r)
        + TW'(CC_TIME_US)) * TW'(CYC_US) + 32'h00000008;
    assign riseLim = TW'(ctrl_r[CTRL_DISCH] ? RISE_DIS_US : RISE_HIZ_US)
        * TW'(CYC_US) + 32'h00000002;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
            sink_r <= 1'b0;
            ccd_r <= '0;
            dly_r <= '0;
            meas_r <= '0;
            acqP_r <= 1'b0;
            seen_r <= 1'b0;
            jdg_r <= 2'h0;
            offCnt_r <= '0;
            ageCnt_r <= '0;
            riseCnt_r <= '0;
        end else begin
            if (regWr) begin
                case (regAddr)
                    REG_CTRL: ctrl_r <= regWdata[CTRL_W-1:0];
                    REG_CC_DELAY: ccd_r <= regWdata[RW-1:0];
                    REG_DELAY: dly_r <= regWdata[RW-1:0];
                    REG_MEAS: meas_r <= regWdata[RW-1:0];
                    default: ;
                endcase
            end
            sink_r <= ctrl_r[CTRL_SINK];
            acqP_r <= acqL;
            seen_r <= seen_r | (acqP_r & ~acqL);
            jdg_r <= {judgePassOut, judgeFailOut};
            offCnt_r <= acqL ? '0 : offCnt_r + 1;
            ageCnt_r <= ({judgePassOut, judgeFailOut} != jdg_r) ? '0
                : ageCnt_r + 1;
            riseCnt_r <= (voltageDriveOut && !vonL) ? riseCnt_r + 1 : '0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_start_drive: assert property ($rose(startIn) && !stopIn
        |=> voltageDriveOut)
        else $error("drive not started after start pulse");
    a_stop_drop: assert property ($rose(stopIn)
        |=> !voltageDriveOut)
        else $error("drive not removed after stop pulse");
    a_measure_trigger_in_clear: assert property ($rose(measureTriggerIn)
        && ctrl_r[CTRL_MODE+:2] == MODE_EXT
        && acqL && mdL && !calRunOut |-> ##2 (!acqL && !mdL))
        else $error("done outputs not cleared by trigger");
    a_md_order: assert property ($rose(mdL) |-> acqL)
        else $error("measurement done before acquisition done");
    a_judge_setup: assert property ($rose(mdL) && seen_r
        |-> ageCnt_r + 2 >= JSET)
        else $error("judgments changed too close to measurement done");
    a_acq_bound: assert property (offCnt_r <= acqLim)
        else $error("acquisition done off too long");
    a_rise_bound: assert property (riseCnt_r <= riseLim)
        else $error("voltage rise too slow");
    a_cal_done: assert property ($fell(calRunOut)
        |-> ##[0:3] (acqL && mdL))
        else $error("done outputs not on after calibration");
endmodule
bind eimh_ext_io eimh_ext_io_chk #(.CYC_US(CYC_US)) eimh_ext_io_chk_inst (.*);
`default_nettype wire

//--- test/eimh_ext_io_bench.sv
`timescale 1ns/100ps
`default_nettype none
module eimh_ext_io_bench;
    import eimh_pkg::*;
    localparam int PW = 200;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [AW-1:0] regAddr = '0;
    logic [DW-1:0] regWdata = '0;
    logic regWr = 1'b0, regRd = 1'b0;
    logic [DW-1:0] regRdata, d;
    logic [2:0] go = 3'h0;
    logic startIn, stopIn, measureTriggerIn;
    logic contactOkIn = 1'b0, voltOkIn = 1'b0, cmpHiIn = 1'b0;
    logic cmpInIn = 1'b0, cmpLoIn = 1'b0, measErrIn = 1'b0;
    logic voltageDriveOut, dischargeOut, calRunOut, acqDoneOut;
    logic measurementDoneOut, contactPassOut, voltCheckPassOut, judgeHiOut;
    logic judgeInOut, judgeLoOut, judgePassOut, judgeFailOut;
    logic measErrOut, voltOnOut;
    logic calPrev = 1'b0;
    int fails = 0, tests_run = 0, calCnt = 0, n;

    eimh_ext_io #(.CYC_US(1), .CAL_SECOND_US_P(2000), .CAL_RUN_US_P(10))
        eimh_ext_io_inst (.*);
    eimh_plc #(.PW(PW)) eimh_plc_inst (.*);

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        calPrev <= calRunOut;
        if (calRunOut === 1'b1 && calPrev === 1'b0) begin
            calCnt <= calCnt + 1;
        end
    end

    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        cyc(1);
        regWr <= 1'b0;
        cyc(1);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [AW-1:0] a);
        regAddr <= a;
        regRd <= 1'b1;
        cyc(1);
        regRd <= 1'b0;
        #1 d = regRdata;
        cyc(1);
    endtask
    task automatic pulse(input logic [2:0] g);
        go <= g;
        cyc(1);
        go <= 3'h0;
        cyc(PW + 2);
    endtask
    task automatic waitFor(ref logic s, input logic v, input int lim,
        input string nm);
        n = 0;
        while (s !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk(nm, v, s);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(95000);
        fails++;
        final_report;
    end

    initial begin
        cyc(10);
        nrst <= 1'b1;
        rd(REG_CTRL);
        chk("ctrl", 32'h0000006A, d);
        rd(8'hFC);
        chk("unmapped", 32'h00000000, d);
        cyc(30);
        chk("acq up", 1'b1, acqDoneOut);
        chk("mdone up", 1'b1, measurementDoneOut);
        pulse(3'h1);
        chk("drive", 1'b1, voltageDriveOut);
        waitFor(voltOnOut, 1'b1, 10100, "von");
        chk("cal runs", 32'h00000002, calCnt);
        contactOkIn <= 1'b1;
        voltOkIn <= 1'b1;
        cmpInIn <= 1'b1;
        wr(REG_CC_DELAY, 32'h00000064);
        wr(REG_DELAY, 32'h0000000A);
        wr(REG_MEAS, 32'h00000014);
        wr(REG_COMP, 32'h0000001E);
        // Start rides along with the trigger and is ignored while driving
        pulse(3'h5);
        chk("acq off", 1'b0, acqDoneOut);
        chk("mdone off", 1'b0, measurementDoneOut);
        cyc(2650);
        chk("contact", 1'b1, contactPassOut);
        waitFor(measurementDoneOut, 1'b1, 20, "mdone");
        chk("pass", 1'b1, judgePassOut);
        chk("fail", 1'b0, judgeFailOut);
        chk("in", 1'b1, judgeInOut);
        chk("vchk", 1'b1, voltCheckPassOut);
        wr(REG_CTRL, 32'h0000002B);
        cyc(2);
        chk("acq sink", 1'b0, acqDoneOut);
        chk("pass sink", 1'b0, judgePassOut);
        rd(REG_STATUS);
        chk("status", 32'h000214AF, d);
        cmpInIn <= 1'b0;
        cmpLoIn <= 1'b1;
        cyc(1000);
        pulse(3'h4);
        waitFor(measurementDoneOut, 1'b0, 3000, "mdone sink");
        chk("fail sink", 1'b0, judgeFailOut);
        chk("lo sink", 1'b0, judgeLoOut);
        chk("pass off", 1'b1, judgePassOut);
        wr(REG_CTRL, 32'h0000002A);
        pulse(3'h2);
        chk("drive off", 1'b0, voltageDriveOut);
        chk("discharging", 1'b1, dischargeOut);
        waitFor(dischargeOut, 1'b0, 10000, "discharged");
        chk("von off", 1'b0, voltOnOut);
        wr(REG_CTRL, 32'h0000002C);
        cmpHiIn <= 1'b1;
        measErrIn <= 1'b1;
        cyc(4000);
        pulse(3'h1);
        waitFor(measurementDoneOut, 1'b0, 11000, "seq start");
        waitFor(measurementDoneOut, 1'b1, 3000, "seq done");
        cyc(3);
        chk("seq drop", 1'b0, voltageDriveOut);
        chk("hi", 1'b1, judgeHiOut);
        chk("err", 1'b1, measErrOut);
        chk("pass err", 1'b0, judgePassOut);
        chk("fail err", 1'b0, judgeFailOut);
        wr(REG_CTRL, 32'h00000028);
        waitFor(acqDoneOut, 1'b0, 100, "int start");
        waitFor(measurementDoneOut, 1'b1, 3000, "int done");
        waitFor(acqDoneOut, 1'b0, 45000, "int again");
        chk("int gap", 1'b1, n >= 35000);
        final_report;
    end
endmodule
`default_nettype wire

//--- test/eimh_plc.sv
`timescale 1ns/100ps
`default_nettype none
module eimh_plc #(
    parameter int PW = 200
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Requests from the bench: {trigger, stop, start}
    input wire logic [2:0] go,
    // Control lines to the device
    output logic startIn,
    output logic stopIn,
    output logic measureTriggerIn
);
    logic [2:0] lvl_r;
    logic [15:0] cnt_r;

    // A request while a pulse runs is dropped, as a real controller would
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lvl_r <= 3'h0;
            cnt_r <= 16'h0000;
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
            if (cnt_r == 16'h0001) begin
                lvl_r <= 3'h0;
            end
        end else if (go != 3'h0) begin
            lvl_r <= go;
            cnt_r <= 16'(PW);
        end
    end
    assign {measureTriggerIn, stopIn, startIn} = lvl_r;
endmodule
`default_nettype wire
